/* src/scp_map.svh */
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
// ascii codes the parser reacts to
`define SCP_NL 8'h0a
`define SCP_SP 8'h20
`define SCP_STAR 8'h2a
`define SCP_PLUS 8'h2b
`define SCP_COMMA 8'h2c
`define SCP_MINUS 8'h2d
`define SCP_DOT 8'h2e
`define SCP_COLON 8'h3a
`define SCP_SEMI 8'h3b
`define SCP_QMARK 8'h3f
`define SCP_CASE 8'h20
// serial timing in oversample ticks and bit index, then keyword length and top level
`define SCP_OS 16
`define SCP_TLAST 4'hf
`define SCP_MID 4'h7
`define SCP_STOP 4'h9
`define SCP_KWLEN 3'h4
`define SCP_TOP 2'h2
// error codes
`define SCP_E_SEP 4'h5
`define SCP_E_LVL 4'h6
`define SCP_E_NUM 4'h7
`define SCP_E_ASC 4'h8
`endif

/* src/scp_pkg.sv */
package scp_pkg;
  // line handling states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ECHO = 4'h2,
    ST_PARSE = 4'h4,
    ST_DONE = 4'h8
  } scp_state_e;
  // parameter formats
  typedef enum logic [2:0] {
    PK_NONE = 3'h0,
    PK_INT = 3'h1,
    PK_FIX = 3'h2,
    PK_SCI = 3'h3,
    PK_MULT = 3'h4,
    PK_STR = 3'h5
  } scp_par_e;
endpackage

/* src/scp_parser.sv */
`timescale 1ns/1ps
`include "scp_map.svh"
// How it works
// R01: frames are 8 data bits, one stop
// R02: async full duplex, start and stop bits
// R03: ascii only in, ascii only out
// R04: host ends each line with newline
// R05: parse on newline or on full buffer
// R06: echo line back when handshake on
// R07: parse error aborts and drops command
// R08: query ends processing of the line
// R09: letters compared case insensitive
// R10: keywords reduced to short form prefix
// R11: colon tree, at most three levels
// R12: semicolon splits commands, keeps path
// R13: space separates header from parameters
// R14: integer, fixed, scientific, multiplier numbers
// R15: twelve multiplier suffixes, any case
// R16: foreign separator raises error five
// R17: question mark marks a query
// R18: handshake echo is a user switch
// R19: buffer depth and baud are parameters
// R20: centre sampling, false start rejected
module scp_parser #(
  parameter int CLK_HZ = 200000000,
  parameter int BAUD = 9600,
  parameter int DEPTH = 64
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic rxd,
  output logic txd,
  input wire logic shake_on,
  input wire logic resp_valid,
  input wire logic [7:0] resp_data,
  output logic resp_ready,
  output logic cmd_valid,
  output logic cmd_query,
  output logic [1:0] cmd_depth,
  output logic [31:0] cmd_kw0,
  output logic [31:0] cmd_kw1,
  output logic [31:0] cmd_kw2,
  output scp_pkg::scp_par_e par_kind,
  output logic par_neg,
  output logic [31:0] par_word,
  output logic [3:0] par_mult,
  output logic err_valid,
  output logic [3:0] err_code
);
  // ****************************************
  // helpers
  // ****************************************
  localparam int AW = $clog2(DEPTH) + 1;
  localparam int DIVR = CLK_HZ / (BAUD * `SCP_OS);
  localparam int DIV = (DIVR < 1) ? 1 : DIVR; // R19
  // upper-case fold
  function automatic logic [7:0] fold(input logic [7:0] c);
    if (c >= "a" && c <= "z") begin
      return c - `SCP_CASE; // R09
    end
    return c;
  endfunction
  function automatic logic is_dig(input logic [7:0] c);
    return c >= "0" && c <= "9";
  endfunction
  function automatic logic is_let(input logic [7:0] c);
    return c >= "A" && c <= "Z";
  endfunction
  // suffix to code 1..12, 0 when unknown
  function automatic logic [3:0] mcode(input logic [15:0] s);
    case (s)
      "EX": return 4'h1; // R15
      "PE": return 4'h2;
      "T": return 4'h3;
      "G": return 4'h4;
      "MA": return 4'h5;
      "K": return 4'h6;
      "M": return 4'h7;
      "U": return 4'h8;
      "N": return 4'h9;
      "P": return 4'ha;
      "F": return 4'hb;
      "A": return 4'hc;
      default: return 4'h0;
    endcase
  endfunction
  // ****************************************
  // baud tick and receiver
  // ****************************************
  logic [31:0] div_q; // oversample divider
  logic tick;
  logic rx_s1_q, rx_s2_q; // pin synchroniser
  logic rx_busy_q;
  logic [3:0] rx_tc_q, rx_bc_q; // tick in bit, bit index
  logic [7:0] rx_sh_q;
  logic rx_v_q; // byte received pulse
  assign tick = div_q == 32'(DIV - 1);
  // divider
  always_ff @(posedge clock) begin
    if (sys_rst || tick) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_q + 32'h0000_0001;
    end
  end
  // two-stage pin sync
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rxd;
      rx_s2_q <= rx_s1_q;
    end
  end
  // receive frame, sampled at bit centre
  always_ff @(posedge clock) begin
    rx_v_q <= 1'b0;
    if (sys_rst) begin
      rx_busy_q <= 1'b0;
      rx_tc_q <= 4'h0;
      rx_bc_q <= 4'h0;
      rx_sh_q <= 8'h00;
    end else if (tick) begin
      if (!rx_busy_q) begin
        rx_busy_q <= !rx_s2_q; // R02
        rx_tc_q <= 4'h0;
        rx_bc_q <= 4'h0;
      end else begin
        rx_tc_q <= rx_tc_q + 4'h1;
        if (rx_tc_q == `SCP_TLAST) begin
          rx_bc_q <= rx_bc_q + 4'h1;
        end
        if (rx_tc_q == `SCP_MID) begin
          if (rx_bc_q == 4'h0 && rx_s2_q) begin
            rx_busy_q <= 1'b0; // R20
          end else if (rx_bc_q == `SCP_STOP) begin
            rx_busy_q <= 1'b0;
            rx_v_q <= rx_s2_q; // R01
          end else if (rx_bc_q != 4'h0) begin
            rx_sh_q <= {rx_s2_q, rx_sh_q[7:1]};
          end
        end
      end
    end
  end
  // ****************************************
  // line buffer and line state
  // ****************************************
  logic [7:0] buf_q [DEPTH];
  logic [AW-1:0] wptr_q, len_q, rptr_q, eptr_q;
  scp_pkg::scp_state_e st_q;
  logic line_end; // newline or buffer full
  logic stop_q; // parser asks for done
  assign line_end = st_q == scp_pkg::ST_IDLE && rx_v_q
    && (rx_sh_q == `SCP_NL || wptr_q == AW'(DEPTH - 1)); // R05 R04
  // store bytes; newline itself is not kept
  always_ff @(posedge clock) begin
    if (st_q == scp_pkg::ST_IDLE && rx_v_q && rx_sh_q != `SCP_NL) begin
      buf_q[wptr_q[AW-2:0]] <= rx_sh_q;
    end
  end
  // write pointer and line length
  always_ff @(posedge clock) begin
    if (sys_rst || st_q == scp_pkg::ST_DONE) begin
      wptr_q <= '0;
      len_q <= '0;
    end else if (st_q == scp_pkg::ST_IDLE && rx_v_q) begin
      if (rx_sh_q != `SCP_NL) begin
        wptr_q <= wptr_q + AW'(1);
      end
      len_q <= (rx_sh_q == `SCP_NL) ? wptr_q : wptr_q + AW'(1);
    end
  end
  // ****************************************
  // transmitter: echo first, then responses
  // ****************************************
  logic tx_busy_q;
  logic [3:0] tx_tc_q, tx_bc_q;
  logic [9:0] tx_sh_q;
  logic txd_q;
  logic tx_load;
  logic [7:0] tx_byte;
  logic echo_last;
  assign echo_last = eptr_q == len_q;
  // bit 7 is cleared on the echo as well, so the wire only ever carries ascii
  assign tx_byte = (st_q == scp_pkg::ST_ECHO)
    ? (echo_last ? `SCP_NL : {1'b0, buf_q[eptr_q[AW-2:0]][6:0]})
    : {1'b0, resp_data[6:0]}; // R03
  assign resp_ready = !tx_busy_q && st_q != scp_pkg::ST_ECHO;
  assign tx_load = !tx_busy_q && (st_q == scp_pkg::ST_ECHO || resp_valid);
  assign txd = txd_q;
  // shift out start, 8 data, stop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_busy_q <= 1'b0;
      tx_tc_q <= 4'h0;
      tx_bc_q <= 4'h0;
      tx_sh_q <= 10'h3ff;
      txd_q <= 1'b1;
    end else begin
      txd_q <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      if (tx_load) begin
        tx_busy_q <= 1'b1;
        tx_tc_q <= 4'h0;
        tx_bc_q <= 4'h0;
        tx_sh_q <= {1'b1, tx_byte, 1'b0}; // R01
      end else if (tx_busy_q && tick) begin
        tx_tc_q <= tx_tc_q + 4'h1;
        if (tx_tc_q == `SCP_TLAST) begin
          tx_sh_q <= {1'b1, tx_sh_q[9:1]};
          tx_bc_q <= tx_bc_q + 4'h1;
          tx_busy_q <= tx_bc_q != `SCP_STOP;
        end
      end
    end
  end
  // line state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q <= scp_pkg::ST_IDLE;
      eptr_q <= '0;
    end else begin
      case (st_q)
        scp_pkg::ST_IDLE: begin
          eptr_q <= '0;
          if (line_end) begin
            st_q <= shake_on ? scp_pkg::ST_ECHO : scp_pkg::ST_PARSE; // R06 R18
          end
        end
        scp_pkg::ST_ECHO: begin
          if (tx_load) begin
            eptr_q <= eptr_q + AW'(1);
            if (echo_last) begin
              st_q <= scp_pkg::ST_PARSE; // R06
            end
          end
        end
        scp_pkg::ST_PARSE: begin
          if (stop_q) begin
            st_q <= scp_pkg::ST_DONE;
          end
        end
        default: st_q <= scp_pkg::ST_IDLE;
      endcase
    end
  end
  // ****************************************
  // parser, one character a cycle
  // ****************************************
  logic [7:0] raw, c;
  logic hdr_q, epend_q;
  logic [1:0] lvl_q;
  logic [31:0] kw_q, mant_q, path_q [3];
  logic [2:0] kwn_q;
  logic [15:0] suf_q;
  scp_pkg::scp_par_e pk_q, fin_k;
  logic neg_q, term, emit, bad;
  assign raw = (rptr_q < len_q) ? buf_q[rptr_q[AW-2:0]] : `SCP_NL;
  assign c = fold(raw);
  assign term = c == `SCP_SEMI || c == `SCP_NL || (hdr_q && c == `SCP_QMARK);
  assign fin_k = (suf_q != 16'h0000) ? scp_pkg::PK_MULT : pk_q; // R14
  assign bad = suf_q != 16'h0000 && mcode(suf_q) == 4'h0;
  // empty command gives no pulse; a parameter field pulses even after an empty header
  assign emit = term && (!hdr_q || kwn_q != 3'h0);
  always_ff @(posedge clock) begin
    cmd_valid <= 1'b0;
    err_valid <= 1'b0;
    if (sys_rst || st_q != scp_pkg::ST_PARSE) begin
      rptr_q <= '0;
      stop_q <= 1'b0;
      hdr_q <= 1'b1;
      lvl_q <= 2'h0;
      kw_q <= 32'h0000_0000;
      kwn_q <= 3'h0;
      pk_q <= scp_pkg::PK_NONE;
      neg_q <= 1'b0;
      mant_q <= 32'h0000_0000;
      suf_q <= 16'h0000;
      epend_q <= 1'b0;
      if (sys_rst) begin
        cmd_query <= 1'b0;
        cmd_depth <= 2'h0;
        par_kind <= scp_pkg::PK_NONE;
        par_neg <= 1'b0;
        par_word <= 32'h0000_0000;
        par_mult <= 4'h0;
        err_code <= 4'h0;
        path_q <= '{default: 32'h0000_0000};
      end
    end else if (!stop_q) begin
      rptr_q <= rptr_q + AW'(1);
      if (raw[7]) begin
        err_valid <= 1'b1; // R03
        err_code <= `SCP_E_ASC;
        stop_q <= 1'b1;
      end else if (term) begin
        if (hdr_q) begin
          path_q[lvl_q] <= kw_q;
        end
        if (!hdr_q && bad) begin
          err_valid <= 1'b1; // R07
          err_code <= `SCP_E_NUM;
          stop_q <= 1'b1;
        end else begin
          cmd_valid <= emit;
          cmd_query <= hdr_q && c == `SCP_QMARK; // R17
          cmd_depth <= lvl_q;
          par_kind <= hdr_q ? scp_pkg::PK_NONE : fin_k;
          par_neg <= neg_q;
          par_word <= mant_q;
          par_mult <= mcode(suf_q);
          stop_q <= c != `SCP_SEMI; // R08
        end
        // next command keeps the current level
        hdr_q <= 1'b1; // R12
        kw_q <= 32'h0000_0000;
        kwn_q <= 3'h0;
        pk_q <= scp_pkg::PK_NONE;
        neg_q <= 1'b0;
        mant_q <= 32'h0000_0000;
        suf_q <= 16'h0000;
        epend_q <= 1'b0;
      end else if (hdr_q) begin
        if (is_let(c) || is_dig(c) || c == `SCP_STAR) begin
          if (kwn_q != `SCP_KWLEN) begin
            kw_q <= {kw_q[23:0], c}; // R10
            kwn_q <= kwn_q + 3'h1;
          end
        end else if (c == `SCP_COLON) begin
          if (kwn_q == 3'h0) begin
            lvl_q <= 2'h0; // leading colon restarts tree
          end else if (lvl_q == `SCP_TOP) begin
            err_valid <= 1'b1; // R11
            err_code <= `SCP_E_LVL;
            stop_q <= 1'b1;
          end else begin
            path_q[lvl_q] <= kw_q;
            lvl_q <= lvl_q + 2'h1; // R11
            kw_q <= 32'h0000_0000;
            kwn_q <= 3'h0;
          end
        end else if (c == `SCP_SP) begin
          path_q[lvl_q] <= kw_q;
          hdr_q <= 1'b0; // R13
          kwn_q <= 3'h0; // string parameter counts from zero
        end else begin
          err_valid <= 1'b1; // R16
          err_code <= `SCP_E_SEP;
          stop_q <= 1'b1;
        end
      end else begin
        // parameter field
        if (is_dig(c)) begin
          if (epend_q) begin
            pk_q <= scp_pkg::PK_SCI; // R14
            suf_q <= 16'h0000;
            epend_q <= 1'b0;
          end else if (suf_q != 16'h0000) begin
            err_valid <= 1'b1;
            err_code <= `SCP_E_NUM;
            stop_q <= 1'b1;
          end else if (pk_q == scp_pkg::PK_NONE || pk_q == scp_pkg::PK_INT) begin
            // only integer part digits are kept, fraction digits are dropped
            mant_q <= 32'(mant_q * 32'd10 + 32'(c - "0"));
            if (pk_q == scp_pkg::PK_NONE) begin
              pk_q <= scp_pkg::PK_INT;
            end
          end
        end else if (c == `SCP_PLUS || c == `SCP_MINUS) begin
          if (epend_q) begin
            pk_q <= scp_pkg::PK_SCI;
            suf_q <= 16'h0000;
            epend_q <= 1'b0;
          end else if (pk_q == scp_pkg::PK_NONE) begin
            neg_q <= c == `SCP_MINUS;
          end
        end else if (c == `SCP_DOT && pk_q != scp_pkg::PK_FIX) begin
          pk_q <= scp_pkg::PK_FIX;
        end else if (is_let(c)) begin
          if (pk_q == scp_pkg::PK_NONE || pk_q == scp_pkg::PK_STR) begin
            pk_q <= scp_pkg::PK_STR;
            if (kwn_q != `SCP_KWLEN) begin
              mant_q <= {mant_q[23:0], c}; // R10
              kwn_q <= kwn_q + 3'h1;
            end
          end else if (suf_q[15:8] == 8'h00) begin
            suf_q <= {suf_q[7:0], c}; // R15
            epend_q <= suf_q == 16'h0000 && c == "E" && pk_q != scp_pkg::PK_SCI;
          end
        end else if (c == `SCP_COMMA) begin
          pk_q <= scp_pkg::PK_NONE;
          mant_q <= 32'h0000_0000;
          suf_q <= 16'h0000;
          neg_q <= 1'b0;
          kwn_q <= 3'h0;
        end else if (c != `SCP_SP) begin
          err_valid <= 1'b1; // R16
          err_code <= `SCP_E_SEP;
          stop_q <= 1'b1;
        end
      end
    end
  end
  assign cmd_kw0 = path_q[0];
  assign cmd_kw1 = path_q[1];
  assign cmd_kw2 = path_q[2];
  // ****************************************
  // checks
  // ****************************************
  property p_txframe;
    @(posedge clock) disable iff (sys_rst) tx_load |=> ##1 !txd_q;
  endproperty
  a_txframe: assert property (p_txframe) else $error("no start bit"); // R01
  property p_stop;
    @(posedge clock) disable iff (sys_rst) rx_v_q |-> $past(rx_s2_q);
  endproperty
  a_stop: assert property (p_stop) else $error("byte without stop"); // R02
  property p_ascii;
    @(posedge clock) disable iff (sys_rst) tx_load |-> !tx_byte[7];
  endproperty
  a_ascii: assert property (p_ascii) else $error("non ascii sent"); // R03
  property p_nl;
    @(posedge clock) disable iff (sys_rst)
      st_q == scp_pkg::ST_IDLE && rx_v_q && rx_sh_q == `SCP_NL |=> st_q != scp_pkg::ST_IDLE;
  endproperty
  a_nl: assert property (p_nl) else $error("newline not taken"); // R05
  property p_echo;
    @(posedge clock) disable iff (sys_rst)
      line_end && shake_on |=> st_q == scp_pkg::ST_ECHO;
  endproperty
  a_echo: assert property (p_echo) else $error("no echo"); // R06
  property p_abort;
    @(posedge clock) disable iff (sys_rst) err_valid |-> !cmd_valid && stop_q;
  endproperty
  a_abort: assert property (p_abort) else $error("error not aborting"); // R07
  property p_query;
    @(posedge clock) disable iff (sys_rst)
      cmd_valid && cmd_query |-> stop_q ##1 st_q == scp_pkg::ST_DONE;
  endproperty
  a_query: assert property (p_query) else $error("query kept parsing"); // R08
  property p_reject;
    @(posedge clock) disable iff (sys_rst)
      tick && rx_busy_q && rx_tc_q == `SCP_MID && rx_bc_q == 4'h0 && rx_s2_q
      |=> !rx_busy_q [*2];
  endproperty
  a_reject: assert property (p_reject) else $error("false start kept"); // R20
endmodule

/* testbench/scp_host.sv */
`timescale 1ns/1ps
// ****************************************
// host serial port model
// ****************************************
module scp_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic clock,
  input wire logic txd,
  output logic rxd
);
  // bytes heard from the device, oldest first
  logic [7:0] rxq[$];
  // line rests at mark level between frames
  initial begin
    rxd = 1'b1;
  end
  // one frame: start bit, 8 data bits lsb first, one stop bit, no parity
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clock);
      #1 rxd = f[i];
      repeat (BIT_CYC - 1) @(posedge clock);
    end
  endtask
  // a low pulse of n cycles, too short to be a start bit
  task automatic glitch(input int n);
    @(posedge clock);
    #1 rxd = 1'b0;
    repeat (n) @(posedge clock);
    #1 rxd = 1'b1;
  endtask
  // receiver, sampling each bit in its middle
  always begin : rx_loop
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clock);
    if (txd === 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clock);
        b[i] = txd;
      end
      repeat (BIT_CYC) @(posedge clock);
      // a frame without its stop bit is thrown away
      if (txd === 1'b1) begin
        rxq.push_back(b);
      end
    end
  end
endmodule

/* testbench/serial_ascii_command_parser_bench.sv */
`timescale 1ns/1ps
`include "scp_map.svh"
// ****************************************
// parser bench, one tick per cycle
// ****************************************
module serial_ascii_command_parser_bench;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic rxd, txd, shake_on = 1'b0, resp_valid = 1'b0, resp_ready;
  logic [7:0] resp_data = 8'h00;
  logic cmd_valid, cmd_query, par_neg, err_valid;
  logic [1:0] cmd_depth;
  logic [31:0] cmd_kw0, cmd_kw1, cmd_kw2, par_word;
  logic [3:0] par_mult, err_code;
  scp_pkg::scp_par_e par_kind;
  int fails = 0;
  int tests_run = 0;
  // command snapshot and the masks used on it
  logic [106:0] vec;
  logic [106:0] all_m = '1;
  logic [106:0] hdr_m = {{67{1'b1}}, 40'h00_0000_0000};
  logic [106:0] cmdq[$];
  logic [3:0] errq[$];
  assign vec = {cmd_query, cmd_depth, cmd_kw0, cmd_kw1, par_kind, par_neg, par_word, par_mult};
  // 200 MHz clock
  always #2.5 clock = ~clock;
  scp_parser #(.BAUD(12500000), .DEPTH(16)) scp_parser_inst (
    .clock(clock), .sys_rst(sys_rst), .rxd(rxd), .txd(txd), .shake_on(shake_on),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_ready(resp_ready),
    .cmd_valid(cmd_valid), .cmd_query(cmd_query), .cmd_depth(cmd_depth),
    .cmd_kw0(cmd_kw0), .cmd_kw1(cmd_kw1), .cmd_kw2(cmd_kw2), .par_kind(par_kind),
    .par_neg(par_neg), .par_word(par_word), .par_mult(par_mult),
    .err_valid(err_valid), .err_code(err_code)
  );
  scp_host scp_host_inst (.clock(clock), .txd(txd), .rxd(rxd));
  // collect every command and error pulse, read mid cycle where settled
  always @(negedge clock) begin
    if (cmd_valid === 1'b1) begin
      cmdq.push_back(vec);
    end
    if (err_valid === 1'b1) begin
      errq.push_back(err_code);
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [106:0] mk(logic q, logic [31:0] k1, logic [2:0] kd, logic n,
                                      logic [31:0] w, logic [3:0] m);
    return {q, 2'h1, 32'h0000_0041, k1, kd, n, w, m};
  endfunction
  // masked compare, unknown bits never match
  task automatic chk(input logic [106:0] got, input logic [106:0] exp, input logic [106:0] m);
    tests_run++;
    if ((got & m) !== (exp & m)) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got & m, exp & m);
    end
  endtask
  // send a line, then wait for ev pulses under a bound
  task automatic run_line(input string s, input int ev, input logic nl);
    cmdq.delete();
    errq.delete();
    scp_host_inst.rxq.delete();
    for (int i = 0; i < s.len(); i++) begin
      scp_host_inst.send(s[i]);
    end
    if (nl) begin
      scp_host_inst.send(`SCP_NL);
    end
    for (int k = 0; k < 3000 && cmdq.size() + errq.size() < ev; k++) begin
      @(posedge clock);
    end
    repeat (60) @(posedge clock);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_query;
    run_line("a:b?", 1, 1'b1);
    chk(cmdq.size(), 1, all_m);
    chk(cmdq[0], mk(1'b1, 32'h0000_0042, 3'h0, 1'b0, 32'h0, 4'h0), hdr_m);
  endtask
  task automatic s_long;
    run_line("display:Page?", 1, 1'b1);
    chk(cmdq[0], {1'b1, 2'h1, 32'h4449_5350, 32'h5041_4745, 40'h0}, hdr_m);
  endtask
  task automatic s_semi;
    run_line("A:B -12;C", 2, 1'b1);
    chk(cmdq.size(), 2, all_m);
    chk(cmdq[0], mk(1'b0, 32'h0000_0042, 3'h1, 1'b1, 32'h0000_000c, 4'h0), all_m);
    chk(cmdq[1], mk(1'b0, 32'h0000_0043, 3'h0, 1'b0, 32'h0, 4'h0), hdr_m);
  endtask
  task automatic s_qend;
    run_line("A:D?;B", 1, 1'b1);
    chk(cmdq.size(), 1, all_m);
    chk(cmdq[0], mk(1'b1, 32'h0000_0044, 3'h0, 1'b0, 32'h0, 4'h0), hdr_m);
  endtask
  task automatic s_sep;
    run_line("A!B", 1, 1'b1);
    chk(cmdq.size(), 0, all_m);
    chk(errq.size(), 1, all_m);
    chk(errq[0], `SCP_E_SEP, all_m);
    run_line("A:B:C 7", 1, 1'b1);
    chk(cmdq[0][105:104], 2'h2, all_m);
    chk(cmd_kw2, 32'h0000_0043, all_m);
    run_line("A:B:C:D", 1, 1'b1);
    chk(cmdq.size(), 0, all_m);
    chk(errq[0], `SCP_E_LVL, all_m);
  endtask
  // a short low pulse on the line must not start a byte
  task automatic s_glitch;
    scp_host_inst.glitch(3);
    repeat (30) @(posedge clock);
    run_line("A", 1, 1'b1);
    chk(errq.size(), 0, all_m);
    chk(cmdq.size(), 1, all_m);
    chk(cmdq[0][103:72], 32'h0000_0041, all_m);
  endtask
  task automatic s_nums;
    string sx[12] = '{"ex", "pe", "t", "g", "ma", "k", "m", "u", "n", "p", "f", "a"};
    run_line("A:B 1.25", 1, 1'b1);
    chk(cmdq[0], mk(1'b0, 32'h0000_0042, 3'h2, 1'b0, 32'h1, 4'h0), all_m);
    run_line("A:B 3.5E+2", 1, 1'b1);
    chk(cmdq[0], mk(1'b0, 32'h0000_0042, 3'h3, 1'b0, 32'h3, 4'h0), all_m);
    run_line("A:B setup", 1, 1'b1);
    chk(cmdq[0], mk(1'b0, 32'h0000_0042, 3'h5, 1'b0, 32'h5345_5455, 4'h0), all_m);
    for (int i = 0; i < 12; i++) begin
      run_line({"A:B 2.5", sx[i]}, 1, 1'b1);
      chk(cmdq[0], mk(1'b0, 32'h0000_0042, 3'h4, 1'b0, 32'h2, 4'(i + 1)), all_m);
    end
  endtask
  task automatic s_echo;
    #1 shake_on = 1'b1;
    run_line("a:x", 1, 1'b1);
    // the closing newline of the echo is still on the wire at the command pulse
    for (int k = 0; k < 400 && scp_host_inst.rxq.size() < 4; k++) begin
      @(posedge clock);
    end
    chk(scp_host_inst.rxq.size(), 4, all_m);
    chk({scp_host_inst.rxq[0], scp_host_inst.rxq[1], scp_host_inst.rxq[2],
         scp_host_inst.rxq[3]}, 32'h613a_780a, all_m);
    chk(cmdq[0], mk(1'b0, 32'h0000_0058, 3'h0, 1'b0, 32'h0, 4'h0), hdr_m);
    #1 shake_on = 1'b0;
  endtask
  // bit 7 of a response byte never reaches the wire
  task automatic s_resp;
    int k;
    scp_host_inst.rxq.delete();
    @(posedge clock);
    #1 resp_valid = 1'b1;
    resp_data = 8'hcf;
    // ready is read once settled; the following edge takes the byte
    for (k = 0; k < 100 && resp_ready !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1 resp_valid = 1'b0;
    chk(resp_ready, 1'b0, all_m);
    for (k = 0; k < 400 && scp_host_inst.rxq.size() == 0; k++) begin
      @(posedge clock);
    end
    chk(scp_host_inst.rxq[0], 8'h4f, all_m);
  endtask
  // 16 bytes fill the 16 deep buffer with no newline
  task automatic s_full;
    run_line("B:CCCCCCCCCCCCCC", 1, 1'b0);
    chk(cmdq.size(), 1, all_m);
    chk(cmdq[0], {1'b0, 2'h1, 32'h0000_0042, 32'h4343_4343, 40'h0}, hdr_m);
  endtask
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (2) @(posedge clock);
    #1 sys_rst = 1'b0;
    chk({txd, resp_ready, cmd_valid, err_valid}, 4'b1100, all_m);
    s_query();
    s_long();
    s_semi();
    s_qend();
    s_sep();
    s_glitch();
    s_nums();
    s_echo();
    s_resp();
    s_full();
    tally_and_finish();
  end
  // cut a hang short well past the expected run
  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end
endmodule
